//--- pkg/tmr_chan_cfg.svh
/*
 * offsets, field positions, reset values and counts of the timer channel
 * assumes: included by bare name from design modules and the bench
 */
`ifndef TMR_CHAN_CFG_SVH
`define TMR_CHAN_CFG_SVH

// apb byte addresses, one aligned word each
`define ADDR_CH_SC 8'h00
`define ADDR_CH_VAL_LO 8'h04
`define ADDR_CH_VAL_HI 8'h08
`define ADDR_TMR_CFG 8'h0C

// channel status/control field positions
`define SC_FLAG_BIT 7
`define SC_IRQ_EN_BIT 6
`define SC_MS_HIGH_BIT 5
`define SC_MS_LOW_BIT 4
`define SC_ELS_HI_BIT 3
`define SC_ELS_LO_BIT 2

// timer configuration field positions
`define CFG_CAS_BIT 0
`define CFG_DIR_BIT 1
`define CFG_PIN_BIT 2

// reset values and the counter zero value
`define SC_RESET 8'h00
`define VAL_RESET 16'h0000
`define CNT_ZERO 16'h0000

// edge/level select codes
`define ELS_NONE 2'b00
`define ELS_TOGGLE 2'b01
`define ELS_CLEAR 2'b10
`define ELS_SET 2'b11

// pin synchroniser depth in bus clocks
`define SYNC_STAGES 2

`endif

//--- pkg/tmr_chan_pkg.sv
/*
 * types shared by the timer channel modules
 * assumes: constants come from tmr_chan_cfg.svh
 */
package tmr_chan_pkg;
    // decoded channel function
    typedef enum logic [2:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EPWM,
        MODE_CPWM
    } chan_mode_t;

    // single-cycle edge pulses of the synchronised pin
    typedef struct packed {
        logic rise;
        logic fall;
    } pin_edges_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage : tmr_chan_pkg

//--- core/pin_edge_sync.sv
/*
 * pin synchroniser and edge detector for the channel input
 * assumes: one bus clock, synchronous active-high reset
 */
`timescale 1ns/1ns
`include "tmr_chan_cfg.svh"
module pin_edge_sync #(
    parameter int STAGES = `SYNC_STAGES // synchroniser depth, at least 2
) (
    input wire logic i_core_clk, // bus clock
    input wire logic i_sys_rst, // synchronous reset, active high
    input wire logic i_pin, // raw channel pin level
    output tmr_chan_pkg::pin_edges_t o_edges, // one-cycle edge pulses
    output logic o_level // synchronised pin level
);
    import tmr_chan_pkg::*;

    logic [STAGES-1:0] sync_reg; // sync chain, bit 0 is the first stage
    logic prev_reg; // last synchronised level, for edge detection

    // chain: the first stage feeds only the next stage
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= {sync_reg[STAGES-2:0], i_pin};
        end
    end

    // previous level, so an edge is a single clean pulse
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sync_reg[STAGES-1];
        end
    end

    assign o_level = sync_reg[STAGES-1];
    assign o_edges.rise = sync_reg[STAGES-1] & ~prev_reg;
    assign o_edges.fall = ~sync_reg[STAGES-1] & prev_reg;
endmodule : pin_edge_sync

//--- core/timer_channel_mode_control.sv
/*
 * one timer/pwm channel: status/control, mode decode, flag, pin action
 * assumes: main counter, modulo and prescaler live outside and feed
 * i_counter, i_cnt_tick and i_count_up; apb master on the bus clock
 */
// Overview of operation
// R1 - capture edge sets the event flag
// R2 - compare or edge pwm match sets flag
// R3 - center pwm sets flag every match
// R4 - irq while flag set and enabled
// R5 - flag clears after read then zero write
// R6 - event between read and write keeps flag
// R7 - reset clears flag, writing one ignored
// R8 - irq enable read/write, reset to zero
// R9 - mode high bit gives edge pwm
// R10 - mode low bit picks capture or compare
// R11 - edge select zero detaches the pin
// R12 - capture edge: rising, falling or both
// R13 - compare action: none, toggle, clear, set
// R14 - edge pwm polarity from edge select
// R15 - center select forces center pwm all channels
// R16 - software keeps pin stable before capture
// R17 - software clears flags after reconfiguring
// R18 - center select makes counter count up/down
// R19 - capture edge copies counter to value
// R20 - status write resets value byte latch
// R21 - pin synchronised before edge detection
`timescale 1ns/1ns
`include "tmr_chan_cfg.svh"
module timer_channel_mode_control (
    input wire logic i_core_clk, // bus clock, 50 MHz
    input wire logic i_sys_rst, // synchronous reset, active high
    input wire tmr_chan_pkg::apb_req_t i_apb, // apb request
    output logic [31:0] o_prdata, // apb read data, registered
    output logic o_pready, // apb ready, registered
    output logic o_pslverr, // unmapped address, registered
    input wire logic [15:0] i_counter, // main counter value
    input wire logic i_cnt_tick, // counter took a new value
    input wire logic i_count_up, // counter counting upward
    input wire logic i_pin, // channel pin level in
    output logic o_pin_out, // channel pin drive level
    output logic o_pin_oe, // high while channel drives pin
    output logic o_pin_release, // pin left to gpio or ext clock
    output logic o_count_updown, // counter in up/down mode
    output logic o_irq_req // channel interrupt request
);
    import tmr_chan_pkg::*;

    // control state
    logic flag_reg; // channel_event_flag
    logic ie_reg; // channel_irq_enable
    logic msh_reg; // mode_select_high
    logic msl_reg; // mode_select_low
    logic [1:0] els_reg; // edge_level_select
    logic cas_reg; // center_aligned_select
    logic armed_reg; // qualifying read seen, clear may follow
    logic [15:0] value_reg; // channel_value
    logic pin_out_reg; // pin drive level

    // value byte coherency
    logic rd_lock_reg; // read buffer holds a snapshot
    logic rd_first_hi_reg; // first byte read was the high one
    logic [15:0] rd_buf_reg; // snapshot for the second byte
    logic [15:0] rd_snap_reg; // value seen when read data was built
    logic [7:0] wr_lo_reg; // pending low byte
    logic [7:0] wr_hi_reg; // pending high byte
    logic got_lo_reg; // low byte written
    logic got_hi_reg; // high byte written

    // bus state
    logic pready_reg; // access completes this cycle
    logic [31:0] prdata_reg; // read data
    logic pslverr_reg; // error answer

    // decoded signals
    chan_mode_t mode; // channel function
    pin_edges_t edges; // pin edge pulses
    logic pin_level; // synchronised pin
    logic xfer; // access completes at this edge
    logic prep; // first access cycle
    logic sc_wr; // write to status/control
    logic sc_rd; // read of status/control
    logic lo_wr, hi_wr; // value byte writes
    logic lo_rd, hi_rd; // value byte reads
    logic mapped; // address hits a register
    logic match; // counter equals channel value
    logic cap_evt; // active capture edge
    logic cmp_evt; // compare or edge pwm match
    logic cpwm_evt; // center pwm match
    logic evt; // any channel event
    logic [15:0] val_view; // value as read by software
    logic [31:0] rd_word; // read mux

    // clean pin edges; a raw async pin would give runt pulses
    pin_edge_sync #(
        .STAGES(`SYNC_STAGES)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_pin),
        .o_edges(edges), // see R21
        .o_level(pin_level)
    );

    // mode decode; center select overrides the mode bits
    always_comb begin
        if (cas_reg) begin
            mode = MODE_CPWM; // see R15
        end else if (msh_reg) begin
            mode = MODE_EPWM; // see R9
        end else if (msl_reg) begin
            mode = MODE_COMPARE; // see R10
        end else begin
            mode = MODE_CAPTURE; // see R10
        end
    end

    // event detection; edge select zero disables capture
    assign match = i_cnt_tick && (i_counter == value_reg);
    assign cap_evt = (mode == MODE_CAPTURE) && // see R1
        ((els_reg[0] && edges.rise) || (els_reg[1] && edges.fall)); // see R12
    assign cmp_evt = match && // see R2
        (mode == MODE_COMPARE || mode == MODE_EPWM);
    assign cpwm_evt = match && (mode == MODE_CPWM); // see R3
    assign evt = cap_evt || cmp_evt || cpwm_evt;

    // apb decode; every access takes one wait state
    assign prep = i_apb.psel && i_apb.penable && !pready_reg;
    assign xfer = i_apb.psel && i_apb.penable && pready_reg;
    assign mapped = (i_apb.paddr == `ADDR_CH_SC) ||
        (i_apb.paddr == `ADDR_CH_VAL_LO) ||
        (i_apb.paddr == `ADDR_CH_VAL_HI) ||
        (i_apb.paddr == `ADDR_TMR_CFG);
    assign sc_wr = xfer && i_apb.pwrite && (i_apb.paddr == `ADDR_CH_SC);
    assign sc_rd = xfer && !i_apb.pwrite && (i_apb.paddr == `ADDR_CH_SC);
    assign lo_wr = xfer && i_apb.pwrite &&
        (i_apb.paddr == `ADDR_CH_VAL_LO);
    assign hi_wr = xfer && i_apb.pwrite &&
        (i_apb.paddr == `ADDR_CH_VAL_HI);
    assign lo_rd = xfer && !i_apb.pwrite &&
        (i_apb.paddr == `ADDR_CH_VAL_LO);
    assign hi_rd = xfer && !i_apb.pwrite &&
        (i_apb.paddr == `ADDR_CH_VAL_HI);

    // capture reads see the snapshot until the pair is complete
    assign val_view = (mode == MODE_CAPTURE && rd_lock_reg) ?
        rd_buf_reg : value_reg;

    // read mux; unused bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (i_apb.paddr)
            `ADDR_CH_SC: begin
                rd_word[7:0] = {flag_reg, ie_reg, msh_reg, msl_reg,
                    els_reg, 2'b00};
            end
            `ADDR_CH_VAL_LO: begin
                rd_word[7:0] = val_view[7:0];
            end
            `ADDR_CH_VAL_HI: begin
                rd_word[7:0] = val_view[15:8];
            end
            `ADDR_TMR_CFG: begin
                rd_word[`CFG_CAS_BIT] = cas_reg;
                rd_word[`CFG_DIR_BIT] = i_count_up;
                rd_word[`CFG_PIN_BIT] = pin_level;
            end
            default: begin
                rd_word = 32'h0000_0000; // unmapped
            end
        endcase
    end

    // bus answer: data and error built in the wait cycle
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            rd_snap_reg <= `VAL_RESET;
        end else begin
            pready_reg <= prep;
            if (prep) begin
                prdata_reg <= i_apb.pwrite ? 32'h0000_0000 : rd_word;
                pslverr_reg <= !mapped;
                rd_snap_reg <= val_view;
            end
        end
    end

    // status/control fields; reset clears them all
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ie_reg <= 1'b0; // see R8
            msh_reg <= 1'b0;
            msl_reg <= 1'b0;
            els_reg <= `ELS_NONE;
        end else if (sc_wr) begin
            ie_reg <= i_apb.pwdata[`SC_IRQ_EN_BIT]; // see R8
            msh_reg <= i_apb.pwdata[`SC_MS_HIGH_BIT];
            msl_reg <= i_apb.pwdata[`SC_MS_LOW_BIT];
            els_reg <= i_apb.pwdata[`SC_ELS_HI_BIT:`SC_ELS_LO_BIT];
        end
    end

    // center select; also steers the external counter direction
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cas_reg <= 1'b0;
        end else if (xfer && i_apb.pwrite &&
                i_apb.paddr == `ADDR_TMR_CFG) begin
            cas_reg <= i_apb.pwdata[`CFG_CAS_BIT]; // see R15
        end
    end

    // clear sequence: a read while set arms, a new event disarms
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            armed_reg <= 1'b0;
        end else if (evt) begin
            armed_reg <= 1'b0; // see R6
        end else if (sc_rd && flag_reg) begin
            armed_reg <= 1'b1; // see R5
        end else if (sc_wr) begin
            armed_reg <= 1'b0;
        end
    end

    // event flag; the set beats the clear in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            flag_reg <= 1'b0; // see R7
        end else if (evt) begin
            flag_reg <= 1'b1; // see R6
        end else if (sc_wr && armed_reg &&
                !i_apb.pwdata[`SC_FLAG_BIT]) begin
            flag_reg <= 1'b0; // see R5
        end
    end

    // read coherency: in capture mode the first byte read freezes both bytes
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || sc_wr || mode != MODE_CAPTURE) begin
            rd_lock_reg <= 1'b0; // see R20
            rd_first_hi_reg <= 1'b0;
            rd_buf_reg <= `VAL_RESET;
        end else if (lo_rd || hi_rd) begin
            if (!rd_lock_reg) begin
                rd_lock_reg <= 1'b1;
                rd_first_hi_reg <= hi_rd;
                rd_buf_reg <= rd_snap_reg;
            end else if (hi_rd != rd_first_hi_reg) begin
                rd_lock_reg <= 1'b0; // pair complete
            end
        end
    end

    // write coherency: outside capture mode both bytes must land before the value moves
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || sc_wr) begin
            got_lo_reg <= 1'b0; // see R20
            got_hi_reg <= 1'b0;
            wr_lo_reg <= 8'h00;
            wr_hi_reg <= 8'h00;
        end else if (mode != MODE_CAPTURE) begin
            if (lo_wr) begin
                wr_lo_reg <= i_apb.pwdata[7:0];
                got_lo_reg <= !got_hi_reg;
                got_hi_reg <= 1'b0;
            end else if (hi_wr) begin
                wr_hi_reg <= i_apb.pwdata[7:0];
                got_hi_reg <= !got_lo_reg;
                got_lo_reg <= 1'b0;
            end
        end
    end

    // channel value: capture copy, coherent pair, or direct byte
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            value_reg <= `VAL_RESET;
        end else if (cap_evt) begin
            value_reg <= i_counter; // see R19
        end else if (mode == MODE_CAPTURE) begin
            // capture mode: software may preset a byte directly
            if (lo_wr) begin
                value_reg[7:0] <= i_apb.pwdata[7:0];
            end else if (hi_wr) begin
                value_reg[15:8] <= i_apb.pwdata[7:0];
            end
        end else if (lo_wr && got_hi_reg) begin
            value_reg <= {wr_hi_reg, i_apb.pwdata[7:0]};
        end else if (hi_wr && got_lo_reg) begin
            value_reg <= {i_apb.pwdata[7:0], wr_lo_reg};
        end
    end

    // pin action per mode; edge pwm period starts at counter zero
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pin_out_reg <= 1'b0;
        end else begin
            unique case (mode)
                MODE_COMPARE: begin
                    if (cmp_evt) begin
                        unique case (els_reg)
                            `ELS_TOGGLE: pin_out_reg <= !pin_out_reg;
                            `ELS_CLEAR: pin_out_reg <= 1'b0;
                            `ELS_SET: pin_out_reg <= 1'b1;
                            `ELS_NONE: pin_out_reg <= pin_out_reg;
                        endcase // see R13
                    end
                end
                MODE_EPWM: begin
                    // match wins over period start, so 0 gives 0% duty
                    if (cmp_evt) begin
                        pin_out_reg <= (els_reg != `ELS_CLEAR); // see R14
                    end else if (i_cnt_tick && i_counter == `CNT_ZERO) begin
                        pin_out_reg <= (els_reg == `ELS_CLEAR); // see R14
                    end
                end
                MODE_CPWM: begin
                    if (cpwm_evt) begin
                        // up-count match ends high-true, down starts it
                        pin_out_reg <= (els_reg == `ELS_CLEAR) ^
                            i_count_up; // see R15
                    end
                end
                MODE_CAPTURE: begin
                    pin_out_reg <= 1'b0; // input only
                end
            endcase
        end
    end

    // outputs
    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_pin_out = pin_out_reg;
    assign o_pin_release = (els_reg == `ELS_NONE); // see R11
    assign o_pin_oe = !o_pin_release && (mode != MODE_CAPTURE); // see R11
    assign o_count_updown = cas_reg; // see R18
    assign o_irq_req = flag_reg && ie_reg; // see R4

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    sequence qual_read_s;
        sc_rd && flag_reg && !evt;
    endsequence
    sequence zero_write_s;
        sc_wr && armed_reg && !i_apb.pwdata[`SC_FLAG_BIT] && !evt;
    endsequence

    flag_capture_a: assert property (cap_evt |=> flag_reg) // see R1
        else $error("capture edge did not set flag");
    flag_match_a: assert property (cmp_evt |=> flag_reg) // see R2
        else $error("compare match did not set flag");
    flag_center_a: assert property (cpwm_evt |=> flag_reg) // see R3
        else $error("center pwm match did not set flag");
    irq_follow_a: assert property (flag_reg && ie_reg |-> o_irq_req) // see R4
        else $error("irq not raised with flag and enable");
    // the zero write needs a full apb access after the read, so at
    // least three cycles apart; a gap event disarms and drops the match
    clear_seq_a: assert property (qual_read_s ##[3:40] zero_write_s // see R5
        |=> !flag_reg)
        else $error("flag not cleared by read then zero write");
    fall_cause_a: assert property ($fell(flag_reg) |->
        $past(armed_reg) && $past(sc_wr)) // see R5
        else $error("flag cleared without clear sequence");
    no_loss_a: assert property (armed_reg && evt // see R6
        |=> flag_reg && !armed_reg)
        else $error("event during clear sequence lost");
    write_one_a: assert property (flag_reg && sc_wr &&
        i_apb.pwdata[`SC_FLAG_BIT] |=> flag_reg) // see R7
        else $error("writing one changed the flag");
    ie_write_a: assert property (sc_wr |=>
        ie_reg == $past(i_apb.pwdata[`SC_IRQ_EN_BIT])) // see R8
        else $error("irq enable not written");
    edge_pwm_a: assert property (!cas_reg && msh_reg // see R9
        |-> mode == MODE_EPWM)
        else $error("mode high bit not giving edge pwm");
    detach_a: assert property (els_reg == `ELS_NONE |-> !o_pin_oe) // see R11
        else $error("pin driven while detached");
    toggle_a: assert property (cmp_evt && mode == MODE_COMPARE &&
        els_reg == `ELS_TOGGLE |=> o_pin_out != $past(o_pin_out)) // see R13
        else $error("compare toggle missing");
    center_up_a: assert property (cpwm_evt && i_count_up &&
        els_reg == `ELS_CLEAR |=> !o_pin_out) // see R15
        else $error("center pwm up match did not clear pin");
    capture_copy_a: assert property (cap_evt |=>
        value_reg == $past(i_counter)) // see R19
        else $error("capture did not copy counter");
    latch_reset_a: assert property (sc_wr |=>
        !rd_lock_reg && !got_lo_reg && !got_hi_reg) // see R20
        else $error("status write did not reset byte latch");
endmodule : timer_channel_mode_control

//--- test/pin_source.sv
/*
 * outside signal source on the timer channel pin
 * assumes: the bench asks for a level; the channel's own driver wins
 * whenever its output enable is high
 */
`timescale 1ns/1ns
module pin_source (
    input wire logic i_core_clk, // bus clock
    input wire logic i_level, // level the outside source wants
    input wire logic i_chan_oe, // channel drives the pin
    input wire logic i_chan_out, // channel drive level
    output logic o_pin // resolved pin level
);
    logic level_reg; // level the source presents

    // changes only after a clock edge, then holds, so the pin is stable
    // for many bus clocks before any mode change of the channel
    always_ff @(posedge i_core_clk) begin
        level_reg <= i_level;
    end

    // source steps back while the channel drives the pin
    assign o_pin = i_chan_oe ? i_chan_out : level_reg;
endmodule : pin_source

//--- test/timer_channel_mode_control_tb.sv
/*
 * self-checking bench for one timer channel over apb
 * assumes: design registers and field codes from tmr_chan_cfg.svh
 */
`timescale 1ns/1ns
`include "tmr_chan_cfg.svh"
`define CHECK_EQ(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module timer_channel_mode_control_tb;
    import tmr_chan_pkg::*;
    logic core_clk = 1'b0; // bus clock
    logic sys_rst = 1'b1; // reset, active high
    apb_req_t req = '0; // apb request towards the design
    logic [31:0] prdata; // apb read data
    logic pready, pslverr; // apb answer
    logic [15:0] counter = 16'h0000; // stand-in main counter
    logic cnt_tick = 1'b0; // counter took a value
    logic count_up = 1'b0; // counter direction
    logic pin_req = 1'b0; // level asked of the source
    logic pin_wire, pin_out, pin_oe, pin_release, count_updown, irq_req;
    logic [31:0] rdata; // last read data
    logic err; // last error response
    int mismatches = 0;
    int checks_done = 0;

    // 50 MHz bus clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    timer_channel_mode_control i_timer_channel_mode_control (
        .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_apb(req),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_counter(counter), .i_cnt_tick(cnt_tick), .i_count_up(count_up),
        .i_pin(pin_wire), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
        .o_pin_release(pin_release), .o_count_updown(count_updown),
        .o_irq_req(irq_req));

    pin_source i_pin_source (.i_core_clk(core_clk), .i_level(pin_req),
        .i_chan_oe(pin_oe), .i_chan_out(pin_out), .o_pin(pin_wire));

    // one apb transfer; waits for pready, the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge core_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: {24'h0000_00, d}};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    // read one register and compare the whole word with the byte zero-extended
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        `CHECK_EQ(rdata, {24'h0000_00, exp})
    endtask : rd_chk

    // flag clear sequence: read status with expected flag, write zero flag
    task automatic clr(input logic [7:0] sc, input logic f);
        rd_chk(`ADDR_CH_SC, {f, sc[6:0]});
        apb(1'b1, `ADDR_CH_SC, sc);
    endtask : clr

    // one counter value with a tick, then let the outputs settle
    task automatic match(input logic [15:0] v);
        @(posedge core_clk);
        counter <= v;
        cnt_tick <= 1'b1;
        @(posedge core_clk);
        cnt_tick <= 1'b0;
        @(negedge core_clk);
    endtask : match

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // cut a hang short
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end

    logic [7:0] sc; // status value under test
    logic [1:0] e; // edge/level code under test
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(`ADDR_CH_SC, 8'h00);
        rd_chk(`ADDR_TMR_CFG, 8'h00);
        `CHECK_EQ(pin_release, 1'b1)
        apb(1'b0, 8'h10, 8'h00);
        `CHECK_EQ(err, 1'b1)
        // capture: each nonzero edge code against a rising and a falling edge
        counter <= 16'h1234;
        for (int k = 1; k < 4; k++) begin
            e = k[1:0];
            sc = {4'h0, e, 2'b00};
            apb(1'b1, `ADDR_CH_SC, sc);
            clr(sc, 1'b0);
            pin_req <= 1'b1;
            repeat (6) @(posedge core_clk);
            `CHECK_EQ(irq_req, 1'b0)
            clr(sc, e[0]);
            rd_chk(`ADDR_CH_VAL_LO, 8'h34);
            rd_chk(`ADDR_CH_VAL_HI, 8'h12);
            pin_req <= 1'b0;
            repeat (6) @(posedge core_clk);
            clr(sc, e[1]);
            `CHECK_EQ(pin_oe, 1'b0)
        end
        // flag clearing, refusals and the interrupt request
        pin_req <= 1'b1;
        repeat (6) @(posedge core_clk);
        apb(1'b1, `ADDR_CH_SC, 8'h4C);
        @(negedge core_clk);
        `CHECK_EQ(irq_req, 1'b1)
        rd_chk(`ADDR_CH_SC, 8'hCC);
        pin_req <= 1'b0;
        repeat (6) @(posedge core_clk);
        apb(1'b1, `ADDR_CH_SC, 8'h4C);
        rd_chk(`ADDR_CH_SC, 8'hCC);
        apb(1'b1, `ADDR_CH_SC, 8'hCC);
        rd_chk(`ADDR_CH_SC, 8'hCC);
        apb(1'b1, `ADDR_CH_SC, 8'h4C);
        @(negedge core_clk);
        `CHECK_EQ(irq_req, 1'b0)
        // compare: flag only, toggle, clear, set
        for (int k = 0; k < 4; k++) begin
            sc = {4'h1, k[1:0], 2'b00};
            apb(1'b1, `ADDR_CH_SC, sc);
            apb(1'b1, `ADDR_CH_VAL_LO, 8'h10);
            apb(1'b1, `ADDR_CH_VAL_HI, 8'h00);
            `CHECK_EQ(pin_release, (k == 0))
            match(16'h0011);
            match(16'h0010);
            `CHECK_EQ(pin_oe, (k != 0))
            if (k != 0) `CHECK_EQ(pin_out, (k != 2))
            clr(sc, 1'b1);
        end
        // edge pwm, both polarities, mode low bit ignored
        for (int k = 0; k < 4; k++) begin
            sc = {2'b00, 1'b1, k[1], k[0] ? 4'h4 : 4'h8};
            apb(1'b1, `ADDR_CH_SC, sc);
            match(16'h0000);
            `CHECK_EQ(pin_out, !k[0])
            match(16'h0010);
            `CHECK_EQ(pin_out, k[0])
            clr(sc, 1'b1);
        end
        // center pwm overrides the mode bits
        apb(1'b1, `ADDR_TMR_CFG, 8'h01);
        @(negedge core_clk);
        `CHECK_EQ(count_updown, 1'b1)
        apb(1'b1, `ADDR_CH_SC, 8'h08);
        count_up <= 1'b1;
        match(16'h0010);
        `CHECK_EQ(pin_out, 1'b0)
        clr(8'h08, 1'b1);
        count_up <= 1'b0;
        match(16'h0010);
        `CHECK_EQ(pin_out, 1'b1)
        clr(8'h08, 1'b1);
        wrap_up();
    end
endmodule : timer_channel_mode_control_tb
